//--- mci_core.v
// Summary of operation
// - call pushes next address, loads immediate into program counter, two cycles.
// - branch loads 13-bit immediate into program counter, stack untouched, two cycles.
// - result target 0 writes accumulator, 1 writes addressed location back.
// - clear writes zero to the addressed location, flags unchanged.
// - watchdog kick resets the watchdog counter in one cycle, flags unchanged.
// - invert complements location, routes result, updates only zero flag.
// - decrement subtracts one, routes result, updates zero flag, one cycle.
// - increment adds one, routes result, updates zero flag, one cycle.
// - decrement-skip subtracts one, routes result, skips next on zero, no flags.
// - increment-skip adds one, routes result, skips next on zero, no flags.
// - a taken skip discards the fetched instruction, running an idle instead.
// - halt freezes the core until an interrupt source asks for wake.
// - or-immediate ORs accumulator with immediate, updates zero flag, one cycle.
// - or-location ORs accumulator with location, routes result, one cycle.
// - load-location copies location into accumulator, flags unchanged.
// - store copies accumulator into the addressed location, flags unchanged.
// - return loads program counter from stack top then pops, two cycles.
`timescale 1ns/100ps
`default_nettype none
`include "mci_defines.vh"

module mci_core (
   // clock and reset
   input  wire                  mclk,
   input  wire                  sys_rst,
   // program memory, synchronous read
   output reg  [`MCI_PC_W-1:0]  prog_addr_ff,
   input  wire [`MCI_IW-1:0]    prog_data,
   // data register file, asynchronous read
   output reg  [`MCI_DW-1:0]    data_rd_addr_ff,
   input  wire [`MCI_DW-1:0]    data_rdata,
   output reg                   data_wr_en_ff,
   output reg  [`MCI_DW-1:0]    data_wr_addr_ff,
   output reg  [`MCI_DW-1:0]    data_wr_data_ff,
   // interrupt wake and watchdog
   input  wire                  wake_req,
   output reg                   wdt_clear_ff,
   output reg                   core_halted_ff,
   // core state
   output reg  [`MCI_DW-1:0]    accum_ff,
   output reg                   zero_flag_ff
);

   // core run state
   localparam ST_RUN  = 1'b0;
   localparam ST_HALT = 1'b1;

   // result of a location operation; immediate operations form their result in the execute case
   // clear, load and store share this path so routing stays in one place
   function [`MCI_DW-1:0] alu_res;
      input [3:0]         op;
      input [`MCI_DW-1:0] opnd;
      input [`MCI_DW-1:0] acc;
      begin
         case (op)
            `MCI_FOP_CLR:   alu_res = `MCI_ZERO8;
            `MCI_FOP_INV:   alu_res = ~opnd;
            `MCI_FOP_DEC,
            `MCI_FOP_DECS:  alu_res = opnd - `MCI_ONE8;
            `MCI_FOP_INC,
            `MCI_FOP_INCS:  alu_res = opnd + `MCI_ONE8;
            `MCI_FOP_OR:    alu_res = acc | opnd;
            `MCI_FOP_LOAD:  alu_res = opnd;
            `MCI_FOP_STORE: alu_res = acc;
            default:        alu_res = `MCI_ZERO8;
         endcase
      end
   endfunction

   // true when a result is all zeros; shared by the skip test and the flag
   function is_zero;
      input [`MCI_DW-1:0] val;
      begin
         is_zero = (val == `MCI_ZERO8);
      end
   endfunction

   // true when a word carries the given system code in its low field
   function sys_is;
      input [`MCI_IW-1:0]   word;
      input [`MCI_PC_W-1:0] code;
      begin
         sys_is = (word[`MCI_K13_F] == code);
      end
   endfunction

   // pipeline state
   reg                  st_ff;
   reg                  squash_ff;
   reg  [`MCI_IW-1:0]   instr_ff;
   reg  [`MCI_SP_W-1:0] sp_ff;
   reg  [`MCI_PC_W-1:0] stack_mem [0:`MCI_STACK_DEPTH-1];

   // combinational controls
   reg  [`MCI_PC_W-1:0] nxt_pc;
   reg                  nxt_st;
   reg                  nxt_squash;
   reg                  push;
   reg                  pop;
   reg  [`MCI_DW-1:0]   res;
   reg                  wr_acc;
   reg                  wr_mem;
   reg                  upd_z;
   reg                  skip_now;
   reg                  kick;

   // return stack top; the pointer wraps silently at the stack depth
   wire [`MCI_SP_W-1:0] sp_top = sp_ff - `MCI_SP_ONE;
   wire [`MCI_PC_W-1:0] stack_top = stack_mem[sp_top];

   // execute stage fields
   wire [2:0]           e_cls = instr_ff[`MCI_CLS_F];
   wire [3:0]           e_op  = instr_ff[`MCI_OP_F];
   wire                 e_dst = instr_ff[`MCI_DST_B];
   wire [`MCI_DW-1:0]   e_adr = instr_ff[`MCI_ADR_F];
   wire [4:0]           e_lop = instr_ff[`MCI_LOP_F];
   wire [`MCI_DW-1:0]   e_k8  = instr_ff[`MCI_K8_F];

   // forward a write still in flight to the location being read
   // the register file only takes a write one edge after the strobe
   wire fwd = data_wr_en_ff && (data_wr_addr_ff == data_rd_addr_ff);
   wire [`MCI_DW-1:0]   opnd = fwd ? data_wr_data_ff : data_rdata;

   // decode stage: a discarded or frozen word becomes an idle
   // a taken skip kills the word decoded in the same cycle; the word
   // behind a jump, a return or reset is stale and squashed as well
   wire d_ok = (st_ff == ST_RUN) && !squash_ff && !skip_now;
   wire [`MCI_IW-1:0]   d_instr = d_ok ? prog_data : `MCI_IDLE_WORD;
   wire [2:0]           d_cls = d_instr[`MCI_CLS_F];
   wire [`MCI_PC_W-1:0] d_k13 = d_instr[`MCI_K13_F];

   // execute stage: data operations, routing and flags
   always @* begin
      res      = `MCI_ZERO8;
      wr_acc   = 1'b0;
      wr_mem   = 1'b0;
      upd_z    = 1'b0;
      skip_now = 1'b0;
      kick     = 1'b0;
      // each class says what it writes, whether it skips and what it kicks
      case (e_cls)
         `MCI_CLS_FILE: begin
            res = alu_res(e_op, opnd, accum_ff);
            case (e_op)
               `MCI_FOP_CLR: begin
                  wr_mem = 1'b1;
               end
               `MCI_FOP_INV, `MCI_FOP_DEC, `MCI_FOP_INC, `MCI_FOP_OR: begin
                  wr_acc = (e_dst == `MCI_DST_ACC);
                  wr_mem = (e_dst != `MCI_DST_ACC);
                  upd_z  = 1'b1;
               end
               `MCI_FOP_DECS, `MCI_FOP_INCS: begin
                  wr_acc   = (e_dst == `MCI_DST_ACC);
                  wr_mem   = (e_dst != `MCI_DST_ACC);
                  skip_now = is_zero(res);
               end
               `MCI_FOP_LOAD: begin
                  wr_acc = 1'b1;
               end
               `MCI_FOP_STORE: begin
                  wr_mem = 1'b1;
               end
               default: begin
                  wr_acc = 1'b0;
               end
            endcase
         end
         `MCI_CLS_LIT: begin
            case (e_lop)
               `MCI_LOP_OR: begin
                  res    = accum_ff | e_k8;
                  wr_acc = 1'b1;
                  upd_z  = 1'b1;
               end
               `MCI_LOP_LOAD: begin
                  res    = e_k8;
                  wr_acc = 1'b1;
               end
               default: begin
                  res = `MCI_ZERO8;
               end
            endcase
         end
         `MCI_CLS_SYS: begin
            kick = sys_is(instr_ff, `MCI_SYS_KICK);
         end
         default: begin
            kick = 1'b0;
         end
      endcase
   end

   // decode stage: program counter, stack and halt control
   always @* begin
      nxt_pc     = prog_addr_ff + `MCI_PC_ONE;
      nxt_st     = st_ff;
      nxt_squash = 1'b0;
      push       = 1'b0;
      pop        = 1'b0;
      // halted: the word after halt stays on the bus at the held address
      if (st_ff == ST_HALT) begin
         // on wake that word is already in flight, so fetch moves past it;
         // holding one more cycle would run the word after halt twice
         if (wake_req) begin
            nxt_st = ST_RUN;
         end else begin
            nxt_pc = prog_addr_ff;
         end
      end else begin
         // flow changes squash the word already fetched behind them
         case (d_cls)
            `MCI_CLS_CALL: begin
               push       = 1'b1;
               nxt_pc     = d_k13;
               nxt_squash = 1'b1;
            end
            `MCI_CLS_JMP: begin
               nxt_pc     = d_k13;
               nxt_squash = 1'b1;
            end
            `MCI_CLS_SYS: begin
               if (sys_is(d_instr, `MCI_SYS_RET)) begin
                  pop        = 1'b1;
                  nxt_pc     = stack_top;
                  nxt_squash = 1'b1;
               end else if (sys_is(d_instr, `MCI_SYS_HALT)) begin
                  nxt_pc = prog_addr_ff;
                  nxt_st = ST_HALT;
               end
            end
            default: begin
               nxt_squash = 1'b0;
            end
         endcase
      end
   end

   // fetch and decode registers
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         prog_addr_ff    <= `MCI_RESET_PC;
         st_ff           <= ST_RUN;
         core_halted_ff  <= 1'b0;
         squash_ff       <= 1'b1; // first word after reset is stale
         instr_ff        <= `MCI_IDLE_WORD;
         data_rd_addr_ff <= `MCI_ZERO8;
         sp_ff           <= `MCI_SP_ZERO;
      end else begin
         prog_addr_ff    <= nxt_pc;
         st_ff           <= nxt_st;
         core_halted_ff  <= (nxt_st == ST_HALT);
         squash_ff       <= nxt_squash;
         instr_ff        <= d_instr;
         data_rd_addr_ff <= d_instr[`MCI_ADR_F];
         // stack pointer follows push and pop
         if (push) begin
            sp_ff <= sp_ff + `MCI_SP_ONE;
         end else if (pop) begin
            sp_ff <= sp_top;
         end
      end
   end

   // return stack storage; the in-flight fetch address is the return address
   // cells need no reset: a pop before any push is a program fault
   always @(posedge mclk) begin
      if (push) begin
         stack_mem[sp_ff] <= prog_addr_ff;
      end
   end

   // execute results
   // accumulator and flag change only when the executing class asks
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         accum_ff        <= `MCI_ZERO8;
         zero_flag_ff    <= 1'b0;
         data_wr_en_ff   <= 1'b0;
         data_wr_addr_ff <= `MCI_ZERO8;
         data_wr_data_ff <= `MCI_ZERO8;
         wdt_clear_ff    <= 1'b0;
      end else begin
         if (wr_acc) begin
            accum_ff <= res;
         end
         // skip forms, loads and stores leave the zero flag alone
         if (upd_z) begin
            zero_flag_ff <= is_zero(res);
         end
         // one-cycle write strobe with its address and data
         data_wr_en_ff   <= wr_mem;
         data_wr_addr_ff <= e_adr;
         data_wr_data_ff <= res;
         wdt_clear_ff    <= kick;
      end
   end

endmodule // mci_core
`default_nettype wire

//--- mci_core_placeholder_none.v
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

//--- mci_core_properties.sv
`timescale 1ns/100ps
`default_nettype none
module mci_props (
   // clock and reset
   input wire logic        mclk,
   input wire logic        sys_rst,
   // fetch and data ports
   input wire logic [12:0] prog_addr_ff,
   input wire logic [15:0] prog_data,
   input wire logic        data_wr_en_ff,
   input wire logic [7:0]  data_wr_addr_ff,
   // core status
   input wire logic        wake_req,
   input wire logic        wdt_clear_ff,
   input wire logic        core_halted_ff,
   input wire logic [7:0]  accum_ff
);
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   // fetch order
   idle_step_a: assert property (
      prog_data == 16'h0000 && !core_halted_ff && !$past(core_halted_ff)
      |=> prog_addr_ff == $past(prog_addr_ff) + 13'h0001)
      else $error("idle word did not advance fetch");
   jump_target_a: assert property (
      prog_data[15:14] == 2'b10 && !core_halted_ff && !$past(prog_data[15])
      |=> prog_addr_ff == $past(prog_data[12:0])) else $error("jump target not loaded");
   // results show two cycles after decode
   kick_pulse_a: assert property (
      wdt_clear_ff |-> $past(prog_data, 2) == 16'h0001) else $error("stray watchdog kick");
   accum_cause_a: assert property (
      $changed(accum_ff) |-> $past(prog_data[15:13], 2) inside {3'h1, 3'h2})
      else $error("accumulator changed without cause");
   write_cause_a: assert property (
      data_wr_en_ff |-> $past(prog_data[15:13], 2) == 3'h1
      && data_wr_addr_ff == $past(prog_data[7:0], 2)) else $error("write without location op");
   // halt and wake
   halt_entry_a: assert property (
      $rose(core_halted_ff) |-> $past(prog_data) == 16'h0002) else $error("halt without cause");
   halt_hold_a: assert property (
      core_halted_ff && !wake_req |=> core_halted_ff && $stable(prog_addr_ff)
      && $stable(accum_ff)) else $error("core moved while halted");
   wake_resume_a: assert property (
      core_halted_ff && wake_req |=> !core_halted_ff) else $error("core did not wake");
   wake_step_a: assert property (
      core_halted_ff && wake_req |=> prog_addr_ff == $past(prog_addr_ff) + 13'h0001)
      else $error("fetch did not step past held word on wake");
endmodule // mci_props
bind mci_core mci_props mci_props_i (.mclk, .sys_rst, .prog_addr_ff, .prog_data,
   .data_wr_en_ff, .data_wr_addr_ff, .wake_req, .wdt_clear_ff, .core_halted_ff, .accum_ff);
`default_nettype wire

//--- mci_defines.vh
`ifndef MCI_DEFINES_VH
`define MCI_DEFINES_VH

// widths
`define MCI_PC_W        13
`define MCI_IW          16
`define MCI_DW          8
`define MCI_SP_W        3
`define MCI_STACK_DEPTH 8

// reset values and small constants
`define MCI_RESET_PC    13'h0000
`define MCI_PC_ONE      13'h0001
`define MCI_SP_ZERO     3'h0
`define MCI_SP_ONE      3'h1
`define MCI_ZERO8       8'h00
`define MCI_ONE8        8'h01
`define MCI_IDLE_WORD   16'h0000

// instruction fields
`define MCI_CLS_F       15:13
`define MCI_OP_F        12:9
`define MCI_DST_B       8
`define MCI_ADR_F       7:0
`define MCI_K13_F       12:0
`define MCI_LOP_F       12:8
`define MCI_K8_F        7:0

// instruction classes
`define MCI_CLS_SYS     3'h0
`define MCI_CLS_FILE    3'h1
`define MCI_CLS_LIT     3'h2
`define MCI_CLS_CALL    3'h4
`define MCI_CLS_JMP     3'h5

// system codes in the low 13 bits
`define MCI_SYS_IDLE    13'h0000
`define MCI_SYS_KICK    13'h0001
`define MCI_SYS_HALT    13'h0002
`define MCI_SYS_RET     13'h0003

// location operations
`define MCI_FOP_CLR     4'h0
`define MCI_FOP_INV     4'h1
`define MCI_FOP_DEC     4'h2
`define MCI_FOP_DECS    4'h3
`define MCI_FOP_INC     4'h4
`define MCI_FOP_INCS    4'h5
`define MCI_FOP_OR      4'h6
`define MCI_FOP_LOAD    4'h7
`define MCI_FOP_STORE   4'h8

// immediate operations
`define MCI_LOP_OR      5'h00
`define MCI_LOP_LOAD    5'h01

// result target
`define MCI_DST_ACC     1'b0

`endif

//--- mci_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
module mci_mem_model (
   // clock and program port
   input  wire logic        mclk,
   input  wire logic [12:0] prog_addr_ff,
   output var  logic [15:0] prog_data,
   // data register port
   input  wire logic [7:0]  data_rd_addr_ff,
   output wire logic [7:0]  data_rdata,
   input  wire logic        data_wr_en_ff,
   input  wire logic [7:0]  data_wr_addr_ff,
   input  wire logic [7:0]  data_wr_data_ff
);
   logic [15:0] prog_mem [0:8191];
   logic [7:0]  data_mem [0:255];
   // program word one cycle after its address
   always @(posedge mclk) prog_data <= prog_mem[prog_addr_ff];
   // same-cycle register read, write on strobe
   assign data_rdata = data_mem[data_rd_addr_ff];
   always @(posedge mclk) if (data_wr_en_ff) data_mem[data_wr_addr_ff] <= data_wr_data_ff;
endmodule // mci_mem_model
`default_nettype wire

//--- mcu_core_instruction_exec_tb.sv
`timescale 1ns/100ps
`default_nettype none
module mcu_core_instruction_exec_tb;
   logic        mclk = 1'b0, sys_rst = 1'b1, wake_req = 1'b0;
   logic [12:0] prog_addr_ff;
   logic [15:0] prog_data;
   logic [7:0]  data_rd_addr_ff, data_rdata, data_wr_addr_ff, data_wr_data_ff, accum_ff;
   logic        data_wr_en_ff, wdt_clear_ff, core_halted_ff, zero_flag_ff;
   int          n_fail = 0, check_count = 0, kicks = 0;
   mci_core mci_core_i (.mclk, .sys_rst, .prog_addr_ff, .prog_data, .data_rd_addr_ff,
      .data_rdata, .data_wr_en_ff, .data_wr_addr_ff, .data_wr_data_ff, .wake_req,
      .wdt_clear_ff, .core_halted_ff, .accum_ff, .zero_flag_ff);
   mci_mem_model mci_mem_model_i (.mclk, .prog_addr_ff, .prog_data, .data_rd_addr_ff,
      .data_rdata, .data_wr_en_ff, .data_wr_addr_ff, .data_wr_data_ff);
   // 125 MHz clock and kick counter
   always #4 mclk = ~mclk;
   always @(posedge mclk) if (wdt_clear_ff === 1'b1) kicks++;
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   function automatic logic [15:0] loc(input int op, input int d, input int a);
      return {3'h1, 4'(op), 1'(d), 8'(a)};
   endfunction
   function automatic logic [15:0] lit(input int op, input int k);
      return {3'h2, 5'(op), 8'(k)};
   endfunction
   task automatic put(input int a, input logic [15:0] w);
      mci_mem_model_i.prog_mem[a] = w;
   endtask
   task automatic dset(input int a, input logic [7:0] v);
      mci_mem_model_i.data_mem[a] = v;
   endtask
   // hold reset and blank both memories
   task automatic clear();
      @(posedge mclk);
      sys_rst <= 1'b1;
      for (int i = 0; i < 8192; i++) put(i, 16'h0000);
      for (int i = 0; i < 256; i++) dset(i, 8'h00);
   endtask
   // bounded wait for the core to halt
   task automatic wait_halt();
      int n;
      n = 0;
      while (core_halted_ff !== 1'b1 && n < 300) begin
         @(negedge mclk);
         n++;
      end
      chk("halted", 8'h01, {7'h0, core_halted_ff});
      repeat (3) @(negedge mclk);
   endtask
   task automatic go();
      repeat (5) @(posedge mclk);
      sys_rst <= 1'b0;
      kicks = 0;
      wait_halt();
   endtask
   task automatic t_alu();
      clear();
      dset('h11, 8'h5a);
      dset('h12, 8'hff);
      put(1, lit(1, 'h23));
      put(2, loc(8, 0, 'h10));
      put(3, loc(1, 0, 'h10));
      put(4, loc(4, 1, 'h10));
      put(5, loc(2, 0, 'h10));
      put(6, lit(0, 'h80));
      put(7, loc(6, 1, 'h10));
      put(8, loc(1, 0, 'h12));
      put(9, loc(0, 0, 'h11));
      put(10, loc(7, 0, 'h10));
      put(11, 16'h0001);
      put(12, 16'h0002);
      go();
      chk("acc", 8'ha7, accum_ff);
      chk("loc10", 8'ha7, mci_mem_model_i.data_mem[8'h10]);
      chk("loc11", 8'h00, mci_mem_model_i.data_mem[8'h11]);
      chk("loc12", 8'hff, mci_mem_model_i.data_mem[8'h12]);
      chk("zero", 8'h01, {7'h0, zero_flag_ff});
      chk("kicks", 8'h01, kicks[7:0]);
   endtask
   task automatic t_skip();
      clear();
      dset('h20, 8'h01);
      dset('h21, 8'hff);
      dset('h22, 8'hff);
      dset('h23, 8'h05);
      put(1, loc(3, 1, 'h20));
      put(2, lit(1, 'h11));
      put(3, loc(8, 0, 'h25));
      put(4, loc(5, 0, 'h21));
      put(5, lit(1, 'h33));
      put(6, loc(8, 0, 'h24));
      put(7, loc(1, 0, 'h22));
      put(8, loc(3, 1, 'h23));
      put(9, lit(1, 'h66));
      put(10, 16'h0002);
      go();
      chk("loc20", 8'h00, mci_mem_model_i.data_mem[8'h20]);
      chk("loc25", 8'h00, mci_mem_model_i.data_mem[8'h25]);
      chk("loc24", 8'h00, mci_mem_model_i.data_mem[8'h24]);
      chk("loc23", 8'h04, mci_mem_model_i.data_mem[8'h23]);
      chk("acc", 8'h66, accum_ff);
      chk("zero", 8'h01, {7'h0, zero_flag_ff});
   endtask
   task automatic t_flow();
      clear();
      put(1, {3'h4, 13'h0100});
      put(2, loc(8, 0, 'h31));
      put(3, {3'h5, 13'h1fff});
      put(4, lit(1, 'hee));
      put('h100, lit(1, 'h11));
      put('h101, 16'h0003);
      put('h102, lit(1, 'h99));
      put('h1fff, 16'h0002);
      go();
      chk("loc31", 8'h11, mci_mem_model_i.data_mem[8'h31]);
      chk("acc", 8'h11, accum_ff);
   endtask
   task automatic t_wake();
      clear();
      put(1, lit(1, 'h5a));
      put(2, 16'h0002);
      put(4, lit(1, 'ha5));
      put(5, 16'h0002);
      go();
      repeat (10) @(negedge mclk);
      chk("held", 8'h01, {7'h0, core_halted_ff});
      chk("acc", 8'h5a, accum_ff);
      @(posedge mclk);
      wake_req <= 1'b1;
      @(posedge mclk);
      wake_req <= 1'b0;
      repeat (2) @(posedge mclk);
      @(negedge mclk);
      chk("awake", 8'h00, {7'h0, core_halted_ff});
      @(negedge mclk);
      chk("rehalt", 8'h01, {7'h0, core_halted_ff});
      wait_halt();
      chk("acc", 8'ha5, accum_ff);
   endtask
   task automatic stop_test();
      if (n_fail == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // scenario sequence and watchdog
   initial begin
      t_alu();
      t_skip();
      t_flow();
      t_wake();
      stop_test();
   end
   initial begin
      #160000;
      n_fail++;
      stop_test();
   end
endmodule // mcu_core_instruction_exec_tb
`default_nettype wire
